// ### verilog/scdr_top.sv
// sample clock edge select, aperture delay and coarse delay ramp with apb registers
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module scdr_top
   import scdr_pkg::*;
#(
   parameter int unsigned DLY_W  = SCDR_DLY_W,   // delay code width
   parameter int unsigned SREF_W = SCDR_SREF_CW  // reference event counter width
) (
   input  wire logic                 pclk,                   // device clock, 200 mhz
   input  wire logic                 presetn,                // async reset, active low
   input  wire logic                 psel,                   // apb select
   input  wire logic                 penable,                // apb access phase
   input  wire logic                 pwrite,                 // apb write
   input  wire logic [SCDR_AW-1:0]   paddr,                  // apb byte address
   input  wire logic [31:0]          pwdata,                 // apb write data
   output logic      [31:0]          prdata,                 // apb read data
   output logic                      pready,                 // apb ready
   output logic                      pslverr,                // apb error, unmapped
   input  wire logic                 sysref_pin,             // timing reference pin
   output logic                      sample_rise_en,         // sample on rising edge
   output logic                      sample_fall_en,         // sample on falling edge
   output logic                      clock_invert_delay,     // half-period inversion
   output logic      [DLY_W-1:0]     coarse_aperture_delay,  // applied coarse code
   output logic      [DLY_W-1:0]     fine_aperture_delay,    // applied fine code
   output logic                      sysref_capture          // reference capture pulse
);
   import scdr_pkg::*;

   initial begin
      if (DLY_W < 1 || DLY_W > 16 || SREF_W < 1 || SREF_W > 32) begin
         $error("scdr_top: unsupported width parameter");
      end
   end

   typedef struct packed {
      logic              single;     // link_format_mode: single-channel
      logic              inv;        // clock_invert_delay setting
      logic              ramp_en;    // delay_ramp_enable
      logic              ramp_fast;  // delay_ramp_speed
      logic [DLY_W-1:0]  target;     // last written coarse value
      logic [DLY_W-1:0]  applied;    // coarse value on the delay line
      logic [DLY_W-1:0]  fine;       // fine value on the delay line
      logic              inv_out;    // inversion on the delay line
      logic              sref_prev;  // last synced reference level
      logic              sref_cap;   // capture pulse
      logic              sref_seen;  // sticky: a reference was caught
      logic [SREF_W-1:0] sref_cnt;   // reference events caught
      logic              smp_rise;   // rising edge sampling enable
      logic              smp_fall;   // falling edge sampling enable
      logic              pready;     // apb ready
      logic              pslverr;    // apb error
      logic [31:0]       prdata;     // apb read data
   } scdr_top_t;

   scdr_top_t   q;
   scdr_top_t   d;
   scdr_ramp_if rif ();

   logic        sref_s;
   logic        setup_ok;
   logic        wr_en;
   logic        wr_ctrl;
   logic        wr_coarse;
   logic        wr_fine;
   logic        wr_status;
   logic        mapped;
   logic        sref_rise;
   logic [31:0] rdata;

   // timing-reference pin is asynchronous to pclk
   scdr_sync2 u_sref_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .async_i (sysref_pin),
      .sync_o  (sref_s)
   );

   // paces ramp steps at one or four per window
   scdr_ramp_timer #(
      .SLOW_PERIOD (SCDR_SLOW_PERIOD),
      .FAST_PERIOD (SCDR_FAST_PERIOD)
   ) u_ramp_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .rif     (rif)
   );

   // address decode and write strobes; a write lands at the ready edge
   always_comb begin
      mapped    = (paddr == SCDR_OFS_CTRL)   || (paddr == SCDR_OFS_COARSE) ||
                  (paddr == SCDR_OFS_FINE)   || (paddr == SCDR_OFS_STATUS) ||
                  (paddr == SCDR_OFS_SREFCNT);
      setup_ok  = psel && penable && q.pready;
      wr_en     = setup_ok && pwrite && mapped;
      wr_ctrl   = wr_en && (paddr == SCDR_OFS_CTRL);
      wr_coarse = wr_en && (paddr == SCDR_OFS_COARSE);
      wr_fine   = wr_en && (paddr == SCDR_OFS_FINE);
      wr_status = wr_en && (paddr == SCDR_OFS_STATUS);
   end

   // read mux, reserved bits read zero
   always_comb begin
      rdata = '0;
      case (paddr)
         SCDR_OFS_CTRL: begin
            rdata[SCDR_CTRL_SINGLE] = q.single;
            rdata[SCDR_CTRL_INV]    = q.inv;
            rdata[SCDR_CTRL_RAMPEN] = q.ramp_en;
            rdata[SCDR_CTRL_FAST]   = q.ramp_fast;
         end
         SCDR_OFS_COARSE: begin
            rdata[DLY_W-1:0] = q.target;
         end
         SCDR_OFS_FINE: begin
            rdata[DLY_W-1:0] = q.fine;
         end
         SCDR_OFS_STATUS: begin
            rdata[DLY_W-1:0]      = q.applied;
            rdata[SCDR_STAT_BUSY] = (q.applied != q.target);
            rdata[SCDR_STAT_SEEN] = q.sref_seen;
         end
         SCDR_OFS_SREFCNT: begin
            rdata[SREF_W-1:0] = q.sref_cnt;
         end
         default: begin
            rdata = '0;
         end
      endcase
   end

   // a coarse write in the same cycle holds the timer off, restarting its period
   assign rif.run  = q.ramp_en && (q.applied != q.target) && !wr_coarse;
   assign rif.fast = q.ramp_fast;

   assign sref_rise = sref_s && !q.sref_prev;

   // next-state logic for the whole block
   always_comb begin
      d = q;

      // one wait state: ready comes on the second access cycle
      d.pready  = psel && penable && !q.pready;
      d.pslverr = psel && penable && !q.pready && !mapped;
      d.prdata  = (psel && penable && !q.pready && !pwrite) ? rdata : q.prdata;

      // settings may be written at any time, even mid-stream
      if (wr_ctrl) begin
         d.single    = pwdata[SCDR_CTRL_SINGLE];
         d.inv       = pwdata[SCDR_CTRL_INV];
         d.ramp_en   = pwdata[SCDR_CTRL_RAMPEN];
         d.ramp_fast = pwdata[SCDR_CTRL_FAST];
      end
      if (wr_fine) begin
         d.fine = pwdata[DLY_W-1:0];
      end

      // ramp off: applied follows target directly, also snaps a dropped ramp
      if (!q.ramp_en) begin
         d.applied = q.target;
      end else if (rif.tick) begin
         // one code per tick, toward target, so it lands exactly on it
         if (q.applied < q.target) begin
            d.applied = q.applied + DLY_W'(1);
         end else if (q.applied > q.target) begin
            d.applied = q.applied - DLY_W'(1);
         end
      end
      if (wr_coarse) begin
         d.target = pwdata[DLY_W-1:0];
         if (!q.ramp_en) begin
            d.applied = pwdata[DLY_W-1:0];
         end
      end

      // inversion follows its bit one cycle later than the coarse/fine codes
      d.inv_out = q.inv;

      // sampling edges by channel mode
      d.smp_rise = 1'b1;
      d.smp_fall = q.single;

      // catch the reference on a fixed pclk edge after the synchroniser
      d.sref_prev = sref_s;
      d.sref_cap  = sref_rise;
      if (sref_rise) begin
         d.sref_cnt = q.sref_cnt + SREF_W'(1);
      end
      // the set wins over a write-one clear in the same cycle
      if (wr_status && pwdata[SCDR_STAT_SEEN]) begin
         d.sref_seen = 1'b0;
      end
      if (sref_rise) begin
         d.sref_seen = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q         <= '0;
         q.target  <= DLY_W'(SCDR_DLY_RST);
         q.applied <= DLY_W'(SCDR_DLY_RST);
         q.fine    <= DLY_W'(SCDR_DLY_RST);
      end else begin
         q <= d;
      end
   end

   // coarse and fine codes leave together, inversion a cycle later: they steer the sample clock, not pclk,
   // so data timing shifts while reference capture keeps its fixed pclk edge
   assign clock_invert_delay    = q.inv_out;
   assign coarse_aperture_delay = q.applied;
   assign fine_aperture_delay   = q.fine;
   assign sample_rise_en        = q.smp_rise;
   assign sample_fall_en        = q.smp_fall;
   assign sysref_capture        = q.sref_cap;
   assign prdata                = q.prdata;
   assign pready                = q.pready;
   assign pslverr               = q.pslverr;

   // helper: cycles since the ramp timer last restarted
   logic [SCDR_TMR_W:0] gap_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_q <= '0;
      end else if (!rif.run || rif.tick) begin
         gap_q <= '0;
      end else begin
         gap_q <= gap_q + (SCDR_TMR_W+1)'(1);
      end
   end

   AST_RISE_ALWAYS: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> sample_rise_en)
      else $error("rising edge sampling not enabled");

   AST_FALL_MODE: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> ##1 (sample_fall_en == $past(pwdata[SCDR_CTRL_SINGLE], 2)))
      else $error("falling edge enable does not follow mode");

   AST_INV_FOLLOW: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> ##1 (clock_invert_delay == $past(pwdata[SCDR_CTRL_INV], 2)))
      else $error("inversion output does not follow setting");

   AST_DIRECT_COARSE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_coarse && !q.ramp_en) |=> (coarse_aperture_delay == $past(pwdata[DLY_W-1:0])))
      else $error("coarse value not applied directly");

   AST_NEW_TARGET: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_coarse && q.ramp_en) |=>
         (q.target == $past(pwdata[DLY_W-1:0])) && $stable(coarse_aperture_delay))
      else $error("ramp write did not retarget cleanly");

   AST_RAMP_STEP: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.ramp_en && rif.tick && !wr_coarse && (q.applied < q.target)) |=>
         (coarse_aperture_delay == $past(q.applied) + DLY_W'(1)))
      else $error("ramp step size or direction wrong");

   AST_RAMP_HOLD: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.ramp_en && !rif.tick && !wr_coarse && !wr_ctrl) |=> $stable(coarse_aperture_delay))
      else $error("coarse moved between ramp steps");

   AST_RAMP_RATE: assert property (
      @(posedge pclk) disable iff (!presetn)
      rif.tick |-> (gap_q == (q.ramp_fast ? (SCDR_TMR_W+1)'(SCDR_FAST_PERIOD - 1)
                                          : (SCDR_TMR_W+1)'(SCDR_SLOW_PERIOD - 1))))
      else $error("ramp step spacing wrong");

   AST_SREF_CAPTURE: assert property (
      @(posedge pclk) disable iff (!presetn)
      ($rose(sref_s) && $past(sref_s) == q.sref_prev) |=> sysref_capture ##1 !sysref_capture)
      else $error("reference not caught on the fixed edge");

   AST_APB_READY: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready ##1 !pready)
      else $error("apb ready not a single cycle");

   AST_FINE_DIRECT: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_fine |=> (fine_aperture_delay == $past(pwdata[DLY_W-1:0])))
      else $error("fine value not applied directly");

   AST_RAMP_DOWN: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rif.tick && (q.applied > q.target)) |=>
         (coarse_aperture_delay == $past(q.applied) - DLY_W'(1)))
      else $error("ramp down step size or direction wrong");

   AST_NO_OVERSHOOT: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.ramp_en && (q.applied == q.target) && !wr_coarse) |=>
         (coarse_aperture_delay == $past(q.target)))
      else $error("ramp moved past its target");

   AST_RAMP_SNAP: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!q.ramp_en && !wr_coarse) |=> (coarse_aperture_delay == $past(q.target)))
      else $error("coarse does not follow target with ramp off");

   AST_FALL_CLEAR: assert property (
      @(posedge pclk) disable iff (!presetn)
      !q.single |=> !sample_fall_en)
      else $error("falling edge sampling enabled in dual mode");

   AST_SEEN_SET: assert property (
      @(posedge pclk) disable iff (!presetn)
      sref_rise |=> q.sref_seen)
      else $error("reference seen flag not set");

   AST_SREF_COUNT: assert property (
      @(posedge pclk) disable iff (!presetn)
      sref_rise |=> (q.sref_cnt == $past(q.sref_cnt) + SREF_W'(1)))
      else $error("reference event count did not advance");

   AST_APB_ERROR: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && !mapped) |=> (pready && pslverr))
      else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// ### verilog/scdr_pkg.sv
// constants shared by the sample clock delay ramp block
`default_nettype none
package scdr_pkg;
   // apb address width and register offsets (byte addresses)
   localparam int unsigned SCDR_AW          = 8;
   localparam logic [7:0]  SCDR_OFS_CTRL    = 8'h00;
   localparam logic [7:0]  SCDR_OFS_COARSE  = 8'h04;
   localparam logic [7:0]  SCDR_OFS_FINE    = 8'h08;
   localparam logic [7:0]  SCDR_OFS_STATUS  = 8'h0c;
   localparam logic [7:0]  SCDR_OFS_SREFCNT = 8'h10;

   // control register field positions
   localparam int unsigned SCDR_CTRL_SINGLE = 0;
   localparam int unsigned SCDR_CTRL_INV    = 1;
   localparam int unsigned SCDR_CTRL_RAMPEN = 2;
   localparam int unsigned SCDR_CTRL_FAST   = 3;

   // status register field positions (applied coarse sits at bit 0)
   localparam int unsigned SCDR_STAT_BUSY   = 8;
   localparam int unsigned SCDR_STAT_SEEN   = 9;

   // delay code width: 256 settings each for coarse and fine
   localparam int unsigned SCDR_DLY_W       = 8;
   localparam logic [7:0]  SCDR_DLY_RST     = 8'h00;

   // ramp pacing: steps per window of device clock cycles
   localparam int unsigned SCDR_RAMP_WINDOW = 256;
   localparam int unsigned SCDR_SLOW_STEPS  = 1;
   localparam int unsigned SCDR_FAST_STEPS  = 4;
   localparam int unsigned SCDR_SLOW_PERIOD = SCDR_RAMP_WINDOW / SCDR_SLOW_STEPS;
   localparam int unsigned SCDR_FAST_PERIOD = SCDR_RAMP_WINDOW / SCDR_FAST_STEPS;
   localparam int unsigned SCDR_TMR_W       = $clog2(SCDR_SLOW_PERIOD);

   // timing-reference event counter width
   localparam int unsigned SCDR_SREF_CW     = 16;
endpackage
`default_nettype wire

// ### verilog/scdr_ramp_if.sv
// ramp pacing handshake between the delay control and its step timer
`timescale 1ns/1ps
`default_nettype none
interface scdr_ramp_if;
   logic run;   // ramp in progress
   logic fast;  // fast pacing selected
   logic tick;  // one step due this cycle

   modport timer (
      input  run,
      input  fast,
      output tick
   );
   modport user (
      output run,
      output fast,
      input  tick
   );
endinterface
`default_nettype wire

// ### verilog/scdr_sync2.sv
// two flip-flop synchroniser for an asynchronous pin level
`timescale 1ns/1ps
`default_nettype none
module scdr_sync2 (
   input  wire logic pclk,     // device clock
   input  wire logic presetn,  // async reset, active low
   input  wire logic async_i,  // level from a pin
   output logic      sync_o    // level on pclk
);
   typedef struct packed {
      logic s1;
      logic s2;
   } scdr_sync_t;

   scdr_sync_t q;
   scdr_sync_t d;

   // first stage feeds only the second stage
   always_comb begin
      d    = q;
      d.s1 = async_i;
      d.s2 = q.s1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.s2;
endmodule
`default_nettype wire

// ### verilog/scdr_ramp_timer.sv
// step timer pacing the coarse delay ramp
`timescale 1ns/1ps
`default_nettype none
module scdr_ramp_timer
   import scdr_pkg::*;
#(
   parameter int unsigned SLOW_PERIOD = SCDR_SLOW_PERIOD,  // cycles per slow step
   parameter int unsigned FAST_PERIOD = SCDR_FAST_PERIOD   // cycles per fast step
) (
   input  wire logic  pclk,     // device clock
   input  wire logic  presetn,  // async reset, active low
   scdr_ramp_if.timer rif       // pacing handshake
);
   localparam int unsigned CW = $clog2(SLOW_PERIOD);

   initial begin
      if (SLOW_PERIOD < 2 || FAST_PERIOD < 1 || FAST_PERIOD > SLOW_PERIOD) begin
         $error("scdr_ramp_timer: unusable step periods");
      end
   end

   localparam logic [CW-1:0] SLOW_LAST = CW'(SLOW_PERIOD - 1);
   localparam logic [CW-1:0] FAST_LAST = CW'(FAST_PERIOD - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
   } scdr_tmr_t;

   scdr_tmr_t     q;
   scdr_tmr_t     d;
   logic [CW-1:0] last;

   // counter restarts whenever the ramp idles, so a new ramp waits a full period
   always_comb begin
      d        = q;
      last     = rif.fast ? FAST_LAST : SLOW_LAST;
      rif.tick = rif.run && (q.cnt >= last);
      if (!rif.run || rif.tick) begin
         d.cnt = '0;
      end else begin
         d.cnt = q.cnt + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// ### tb/scdr_srcgen.sv
// behavioural clock source model driving the timing reference pin
`timescale 1ns/1ps
`default_nettype none
module scdr_srcgen #(
   parameter int unsigned R_LANE  = 2,  // rate factor of the link mode
   parameter int unsigned F_OCT   = 1,  // octets per frame
   parameter int unsigned K_FRM   = 4,  // frames per multiframe
   parameter int unsigned N_DIV   = 1,  // integer division of the rate
   parameter int unsigned PULSE_W = 4   // single pulse width in cycles
) (
   input  wire logic pclk,      // device clock
   input  wire logic periodic,  // continuous reference wanted
   input  wire logic fire,      // request one single pulse
   output logic      sysref     // timing reference pin
);
   localparam int unsigned PER = (10 * F_OCT * K_FRM * N_DIV) / R_LANE;
   int   cnt   = 0;
   int   pw    = 0;
   logic fire_d = 1'b0;
   initial sysref = 1'b0;
   // periodic reference or one pulse per request, both edge aligned to the clock
   always @(posedge pclk) begin
      fire_d <= fire;
      if (periodic) begin
         cnt    <= (cnt == PER - 1) ? 0 : cnt + 1;
         sysref <= (cnt < PER / 2);
      end else if (fire && !fire_d) begin
         pw     <= PULSE_W - 1;
         sysref <= 1'b1;
      end else if (pw > 0) begin
         pw <= pw - 1;
      end else begin
         cnt    <= 0;
         sysref <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### tb/sample_clock_delay_ramp_bench.sv
// self-checking bench for the sample clock delay ramp block
`timescale 1ns/1ps
`default_nettype none
module sample_clock_delay_ramp_bench;
   import scdr_pkg::*;
   typedef struct packed {logic w; logic e; logic [31:0] d;} scdr_exp_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sysref_pin;
   logic [7:0]  paddr, coarse_aperture_delay, fine_aperture_delay;
   logic [31:0] pwdata, prdata, seed;
   logic        sample_rise_en, sample_fall_en, clock_invert_delay, sysref_capture;
   logic        periodic, fire, pin_d;
   int          err_count, tests_run, cyc, rises, caps, t_rise, lat0;
   scdr_exp_t   q[$];

   scdr_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sysref_pin(sysref_pin), .sample_rise_en(sample_rise_en),
      .sample_fall_en(sample_fall_en), .clock_invert_delay(clock_invert_delay),
      .coarse_aperture_delay(coarse_aperture_delay),
      .fine_aperture_delay(fine_aperture_delay), .sysref_capture(sysref_capture));
   scdr_srcgen src (.pclk(pclk), .periodic(periodic), .fire(fire), .sysref(sysref_pin));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic settle(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask

   // one apb transfer; d is write data or the expected read word
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic e);
      q.push_back('{w, e, d});
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= w ? d : 32'h0;
      @(posedge pclk);
      penable <= 1'b1;
      // no own limit: only the run timeout ends a hung transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ramp walk: each step one code toward the target, paced by the period
   task automatic ramp_watch(input logic [7:0] from, input logic [7:0] to, input int per);
      logic [7:0] cur;
      int         gap, n;
      cur = from; gap = 0; n = 0;
      while (cur !== to && n < 3000) begin
         settle(1);
         gap++; n++;
         if (coarse_aperture_delay !== cur) begin
            cur = (to > cur) ? cur + 8'h01 : cur - 8'h01;
            chk("ramp_step", cur, coarse_aperture_delay);
            chk("ramp_gap", 1, gap >= per - 6 && gap <= per + 2);
            gap = 0;
         end
      end
      settle(2 * per);
      chk("ramp_rest", to, coarse_aperture_delay);
   endtask

   // bus monitor: oldest note against each completed transfer
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (q.size() == 0) chk("queue", 1, 0);
         else begin
            chk("pslverr", q[0].e, pslverr);
            if (!q[0].w) chk("prdata", q[0].d, prdata);
            void'(q.pop_front());
         end
      end
   end

   // reference monitor and run limit; capture latency must never vary
   always @(posedge pclk) begin
      cyc++;
      pin_d <= sysref_pin;
      if (sysref_pin && !pin_d) begin
         rises++;
         t_rise = cyc;
      end
      if (sysref_capture === 1'b1) begin
         caps++;
         if (caps == 1) lat0 = cyc - t_rise;
         chk("sref_lat", lat0, cyc - t_rise);
      end
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end

   initial begin
      logic [7:0] c, f;
      int         n;
      seed = 32'h2e; err_count = 0; tests_run = 0; cyc = 0; rises = 0; caps = 0;
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; periodic = 0; fire = 0; pin_d = 0; t_rise = 0; lat0 = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) apb(1'b0, 8'(4 * i), 32'h0, 1'b0);
      settle(1);
      chk("rise_en", 1, sample_rise_en);
      chk("fall_en", 0, sample_fall_en);
      $display("test reset done");
      apb(1'b1, SCDR_OFS_CTRL, 32'h1 << SCDR_CTRL_SINGLE, 1'b0);
      settle(3);
      chk("fall_en", 1, sample_fall_en);
      chk("rise_en", 1, sample_rise_en);
      apb(1'b1, SCDR_OFS_CTRL, 32'h1 << SCDR_CTRL_INV, 1'b0);
      settle(3);
      chk("fall_en", 0, sample_fall_en);
      chk("invert", 1, clock_invert_delay);
      apb(1'b0, SCDR_OFS_CTRL, 32'h2, 1'b0);
      $display("test modes done");
      for (int i = 0; i < 6; i++) begin
         c = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'(xs());
         f = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'(xs());
         apb(1'b1, SCDR_OFS_COARSE, {24'h0, c}, 1'b0);
         apb(1'b1, SCDR_OFS_FINE, {24'h0, f}, 1'b0);
         settle(2);
         chk("coarse", c, coarse_aperture_delay);
         chk("fine", f, fine_aperture_delay);
         chk("invert", 1, clock_invert_delay);
         apb(1'b0, SCDR_OFS_COARSE, {24'h0, c}, 1'b0);
      end
      apb(1'b1, 8'h14, 32'h5a, 1'b1);
      apb(1'b0, 8'h14, 32'h0, 1'b1);
      apb(1'b0, SCDR_OFS_FINE, {24'h0, f}, 1'b0);
      $display("test direct delays done");
      apb(1'b1, SCDR_OFS_COARSE, 32'h80, 1'b0);
      apb(1'b1, SCDR_OFS_CTRL, 32'he, 1'b0);
      settle(3);
      apb(1'b1, SCDR_OFS_COARSE, 32'h83, 1'b0);
      apb(1'b0, SCDR_OFS_STATUS, 32'h180, 1'b0);
      ramp_watch(8'h80, 8'h83, 64);
      apb(1'b0, SCDR_OFS_STATUS, 32'h083, 1'b0);
      apb(1'b1, SCDR_OFS_CTRL, 32'h6, 1'b0);
      apb(1'b1, SCDR_OFS_COARSE, 32'h81, 1'b0);
      ramp_watch(8'h83, 8'h81, 256);
      apb(1'b1, SCDR_OFS_CTRL, 32'he, 1'b0);
      apb(1'b1, SCDR_OFS_COARSE, 32'h85, 1'b0);
      n = 0;
      while (coarse_aperture_delay !== 8'h82 && n < 200) begin
         settle(1);
         n++;
      end
      apb(1'b1, SCDR_OFS_COARSE, 32'h80, 1'b0);
      ramp_watch(8'h82, 8'h80, 64);
      $display("test ramp done");
      for (int i = 0; i < 2; i++) begin
         @(posedge pclk);
         fire <= 1'b1;
         repeat (10) @(posedge pclk);
         fire <= 1'b0;
         repeat (10) @(posedge pclk);
      end
      @(posedge pclk);
      periodic <= 1'b1;
      for (int i = 0; i < 20; i++) apb(1'b1, SCDR_OFS_FINE, xs() & 32'hff, 1'b0);
      @(posedge pclk);
      periodic <= 1'b0;
      settle(30);
      chk("captures", rises, caps);
      apb(1'b0, SCDR_OFS_SREFCNT, rises, 1'b0);
      apb(1'b0, SCDR_OFS_STATUS, 32'h280, 1'b0);
      apb(1'b1, SCDR_OFS_STATUS, 32'h200, 1'b0);
      apb(1'b0, SCDR_OFS_STATUS, 32'h080, 1'b0);
      settle(2);
      $display("test reference done");
      // reset in mid-run: coarse code, rising edge enable and inversion must fall back to zero
      @(posedge pclk);
      presetn <= 1'b0;
      settle(2);
      chk("rst_coarse", 0, coarse_aperture_delay);
      chk("rst_rise", 0, sample_rise_en);
      chk("rst_invert", 0, clock_invert_delay);
      @(posedge pclk);
      presetn <= 1'b1;
      settle(1);
      chk("rise_en", 1, sample_rise_en);
      apb(1'b0, SCDR_OFS_STATUS, 32'h0, 1'b0);
      apb(1'b0, SCDR_OFS_CTRL, 32'h0, 1'b0);
      $display("test mid reset done");
      conclude();
   end
endmodule
`default_nettype wire
